// ### core/psq_sequencer.v
// serial control port, wake latch and rail sequencing of the power sequencer
`timescale 1ns/10ps
`default_nettype none
`include "psq_map.vh"

module psq_sequencer #(
    parameter WAKE_TIMEOUT_CYC = `PSQ_WAKE_TIMEOUT_US * `PSQ_CLK_MHZ
) (
    input wire clk_sys_in, // system clock, 125 MHz
    input wire arst_n_in, // power-on reset, active low
    input wire shift_clock_in, // serial shift clock
    input wire serial_data_in, // serial data
    input wire load_strobe_in, // frame load strobe
    input wire wake_request_n_1_in, // wake request 1, active low
    input wire wake_request_n_2_in, // wake request 2, active low
    input wire wake_request_n_3_in, // wake request 3, active low
    input wire wake_request_n_4_in, // wake request 4, active low
    input wire ack_pin_in, // acknowledge pin, high active
    input wire standby_pin_in, // standby request pin, high active
    input wire rail_order_pick_in, // 1: standby rail, 0: ground
    input wire rail1_internal_ok_in, // converter 1 rail above reference
    input wire rail2_internal_ok_in, // converter 2 rail above reference
    input wire rail1_external_ok_in, // delayed rail 1 good
    input wire rail2_external_ok_in, // delayed rail 2 good
    input wire gate_level_pick_1_in, // gate level select bit 1
    input wire gate_level_pick_2_in, // gate level select bit 2
    output reg wake_held_out, // held wake state
    output reg gate_supply_on_out, // gate supply booster run
    output reg converter1_on_out, // converter 1 run
    output reg converter2_on_out, // converter 2 run
    output reg power_switch_1_on_out, // switched rail 1 on
    output reg power_switch_2_on_out, // switched rail 2 on
    output reg linear_regulator_1_on_out, // linear 1 run
    output reg linear_regulator_2_on_out, // linear 2 run
    output reg linear_regulator_3_on_out, // linear 3 run
    output reg key_latch_pulldown_out, // low-side switch on
    output reg rail1_ok_n_out, // rail 1 reset, active low
    output reg rail2_ok_n_out, // rail 2 reset, active low
    output reg [1:0] gate_level_out, // gate supply target code
    output reg [7:0] switching_clock_config_out, // clock and gate settings
    output reg [7:0] converter1_voltage_code_out, // converter 1 code
    output reg [7:0] converter2_voltage_code_out, // converter 2 code
    output reg [7:0] linear1_voltage_code_out, // linear 1 code
    output reg [7:0] linear2_voltage_code_out, // linear 2 code
    output reg [7:0] linear3_voltage_code_out // linear 3 code
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    localparam NSYNC = 16;
    localparam [19:0] TO_CYC = WAKE_TIMEOUT_CYC[19:0];
    wire [NSYNC-1:0] raw_w;
    wire [NSYNC-1:0] s_w;
    assign raw_w = {gate_level_pick_2_in, gate_level_pick_1_in, rail2_external_ok_in,
                    rail1_external_ok_in, rail2_internal_ok_in, rail1_internal_ok_in,
                    rail_order_pick_in, standby_pin_in, ack_pin_in,
                    wake_request_n_4_in, wake_request_n_3_in, wake_request_n_2_in,
                    wake_request_n_1_in, load_strobe_in, serial_data_in, shift_clock_in};

    psq_sync2 #(.WIDTH(NSYNC)) u_sync (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .async_in(raw_w),
        .sync_out(s_w)
    );

    wire sck_w = s_w[0];
    wire sdat_w = s_w[1];
    wire load_strobe_w = s_w[2];
    wire [3:0] wake_n_w = s_w[6:3];
    wire ack_pin_w = s_w[7];
    wire sby_pin_w = s_w[8];
    wire pick_w = s_w[9];
    wire r1i_w = s_w[10];
    wire r2i_w = s_w[11];
    wire r1e_w = s_w[12];
    wire r2e_w = s_w[13];

    // ----------------------------------------------------------------
    // serial shift and load
    // ----------------------------------------------------------------
    reg sck_d_r;
    reg load_strobe_d_r;
    reg [`PSQ_FRAME_BITS-1:0] shift_r;
    reg [7:0] rail_mask_r;
    reg [7:0] ctrl_r;
    wire sck_rise_w = sck_w & ~sck_d_r;
    wire load_strobe_rise_w = load_strobe_w & ~load_strobe_d_r;
    wire [3:0] faddr_w = shift_r[`PSQ_ADDR_MSB:`PSQ_ADDR_LSB];
    wire [7:0] fdata_w = shift_r[7:0];

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sck_d_r <= 1'b0;
            load_strobe_d_r <= 1'b0;
            shift_r <= 12'h000;
        end else begin
            sck_d_r <= sck_w;
            load_strobe_d_r <= load_strobe_w;
            if (sck_rise_w) begin
                shift_r <= {shift_r[`PSQ_FRAME_BITS-2:0], sdat_w};
            end
        end
    end

    // older bits fall off the top, so only the last twelve count
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rail_mask_r <= `PSQ_RST_RAIL_ENABLE_MASK;
            switching_clock_config_out <= `PSQ_RST_OTHER;
            converter1_voltage_code_out <= `PSQ_RST_OTHER;
            converter2_voltage_code_out <= `PSQ_RST_OTHER;
            linear1_voltage_code_out <= `PSQ_RST_OTHER;
            linear2_voltage_code_out <= `PSQ_RST_OTHER;
            linear3_voltage_code_out <= `PSQ_RST_OTHER;
            ctrl_r <= `PSQ_RST_OTHER;
        end else if (load_strobe_rise_w) begin
            case (faddr_w)
                `PSQ_ADDR_RAIL_ENABLE_MASK: rail_mask_r <= fdata_w;
                `PSQ_ADDR_SWITCHING_CLOCK_CONFIG: switching_clock_config_out <= fdata_w;
                `PSQ_ADDR_CONVERTER1_VOLTAGE_CODE: converter1_voltage_code_out <= fdata_w;
                `PSQ_ADDR_CONVERTER2_VOLTAGE_CODE: converter2_voltage_code_out <= fdata_w;
                `PSQ_ADDR_LINEAR1_VOLTAGE_CODE: linear1_voltage_code_out <= fdata_w;
                `PSQ_ADDR_LINEAR2_VOLTAGE_CODE: linear2_voltage_code_out <= fdata_w;
                `PSQ_ADDR_LINEAR3_VOLTAGE_CODE: linear3_voltage_code_out <= fdata_w;
                `PSQ_ADDR_WAKE_ACK_STANDBY_CTRL: ctrl_r <= fdata_w;
                default: ctrl_r <= ctrl_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // wake latch and timeout
    // ----------------------------------------------------------------
    reg [3:0] wake_n_d_r;
    reg latch_r;
    reg [19:0] to_cnt_r;
    reg timeout_r;
    wire ack_w = ack_pin_w | ctrl_r[`PSQ_CTRL_ACK];
    wire sby_w = sby_pin_w | ctrl_r[`PSQ_CTRL_STANDBY];
    // completion goods chosen by rail order pick
    wire ext_good_w = pick_w ? r2e_w : r1e_w;
    wire lin_good_w = pick_w ? r2i_w : r1i_w;
    // ack and standby held off until the chosen rail is good
    wire ack_ok_w = ack_w & ext_good_w;
    wire sby_ok_w = sby_w & ext_good_w & ~ack_w;
    wire [3:0] wake_fall_w = wake_d_fall(wake_n_w, wake_n_d_r);
    wire wake_evt_w = |wake_fall_w;

    function [3:0] wake_d_fall;
        input [3:0] now_v;
        input [3:0] old_v;
        begin
            wake_d_fall = old_v & ~now_v;
        end
    endfunction

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_n_d_r <= 4'h0; // syncs reset low: a high value here fakes a wake edge
            latch_r <= 1'b0;
            wake_held_out <= 1'b0;
            to_cnt_r <= 20'h00000;
            timeout_r <= 1'b0;
        end else begin
            wake_n_d_r <= wake_n_w;
            if (ack_ok_w) begin
                latch_r <= 1'b0;
            end else if (wake_evt_w && !latch_r) begin
                latch_r <= 1'b1;
            end
            if (wake_evt_w && !latch_r && !ack_ok_w) begin
                wake_held_out <= 1'b1;
            end else if (sby_ok_w || timeout_r) begin
                wake_held_out <= 1'b0;
            end
            // timeout runs while wake is held but not yet acknowledged
            if (latch_r && wake_held_out && !ack_ok_w) begin
                to_cnt_r <= to_cnt_r + 20'h00001;
                timeout_r <= (to_cnt_r >= TO_CYC - 20'h00001);
            end else begin
                to_cnt_r <= 20'h00000;
                timeout_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // rail sequencing and reset outputs
    // ----------------------------------------------------------------
    wire all_good_w = r1i_w & r1e_w & r2i_w;
    wire lin_run_w = all_good_w | lin_good_w;

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gate_supply_on_out <= 1'b0;
            converter1_on_out <= 1'b0;
            converter2_on_out <= 1'b0;
            power_switch_1_on_out <= 1'b0;
            power_switch_2_on_out <= 1'b0;
            linear_regulator_1_on_out <= 1'b0;
            linear_regulator_2_on_out <= 1'b0;
            linear_regulator_3_on_out <= 1'b0;
            key_latch_pulldown_out <= 1'b0;
            rail1_ok_n_out <= 1'b0;
            rail2_ok_n_out <= 1'b0;
            gate_level_out <= 2'h0;
        end else begin
            gate_supply_on_out <= wake_held_out;
            converter1_on_out <= wake_held_out & rail_mask_r[`PSQ_RAIL_CONV1];
            converter2_on_out <= wake_held_out & all_good_w
                & rail_mask_r[`PSQ_RAIL_CONV2];
            power_switch_1_on_out <= wake_held_out & all_good_w
                & rail_mask_r[`PSQ_RAIL_SW1];
            // switch 2 follows converter 2 being enabled
            power_switch_2_on_out <= wake_held_out & all_good_w
                & rail_mask_r[`PSQ_RAIL_SW2] & rail_mask_r[`PSQ_RAIL_CONV2];
            linear_regulator_1_on_out <= wake_held_out & lin_run_w
                & rail_mask_r[`PSQ_RAIL_LIN1];
            linear_regulator_2_on_out <= wake_held_out & lin_run_w
                & rail_mask_r[`PSQ_RAIL_LIN2];
            linear_regulator_3_on_out <= wake_held_out & lin_run_w
                & rail_mask_r[`PSQ_RAIL_LIN3];
            key_latch_pulldown_out <= ack_w & r1i_w;
            rail1_ok_n_out <= r1i_w;
            rail2_ok_n_out <= r2i_w;
            gate_level_out <= s_w[15:14];
        end
    end
endmodule // psq_sequencer

`default_nettype wire

// ### core/psq_map.vh
// register map, field positions and timing constants of the power sequencer control
//
// Behaviour
// - each load strobe rise moves the last twelve shifted bits into the addressed register
// - frames arrive address first, msb first: address, data high nibble, data low nibble
// - address 1 rails, 2 clock/gate, 3-7 voltage codes, 8 acknowledge/standby
// - power-on reset initialises every serial control register before any frame
// - wake state low stops gate booster, both converters, switched rails and linears
// - wake without rail-good runs booster and converter 1; linears once rail-1 ok, pick low
// - wake with all rail-good runs converter 2, switched rails and linears too
// - rail order pick high uses rail-2 goods, low uses rail-1 goods
// - acknowledge clears the internal wake request latches
// - new wake requests are ignored until acknowledge has cleared the latch
// - any of four active-low wake requests wakes the device, combined as OR
// - acknowledge switches on the low-side key latch pulldown output while converter-1 rail is above reference
// - rail-1 reset output stays low while converter-1 rail is below reference
// - rail-2 reset output tracks converter-2 rail the same way
// - gate supply target level is chosen by the two gate level pick inputs
// - a wake request edge sets the wake latch, driving the held wake state high
// - after acknowledge reset the latch, standby request drops the held wake state
// - no acknowledge before wake timeout puts the device into sleep
// - the load happens on the strobe low-to-high edge using the last 12 bits
`ifndef PSQ_MAP_VH
`define PSQ_MAP_VH

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define PSQ_FRAME_BITS 12
`define PSQ_ADDR_MSB 11
`define PSQ_ADDR_LSB 8

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PSQ_ADDR_RAIL_ENABLE_MASK 4'h1
`define PSQ_ADDR_SWITCHING_CLOCK_CONFIG 4'h2
`define PSQ_ADDR_CONVERTER1_VOLTAGE_CODE 4'h3
`define PSQ_ADDR_CONVERTER2_VOLTAGE_CODE 4'h4
`define PSQ_ADDR_LINEAR1_VOLTAGE_CODE 4'h5
`define PSQ_ADDR_LINEAR2_VOLTAGE_CODE 4'h6
`define PSQ_ADDR_LINEAR3_VOLTAGE_CODE 4'h7
`define PSQ_ADDR_WAKE_ACK_STANDBY_CTRL 4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PSQ_RST_RAIL_ENABLE_MASK 8'hff
`define PSQ_RST_OTHER 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PSQ_RAIL_SW1 7
`define PSQ_RAIL_SW2 6
`define PSQ_RAIL_CONV1 5
`define PSQ_RAIL_SWR2 4
`define PSQ_RAIL_LIN1 3
`define PSQ_RAIL_LIN2 2
`define PSQ_RAIL_LIN3 1
`define PSQ_RAIL_CONV2 0
`define PSQ_CLK_EXT 7
`define PSQ_CLK_HALF 6
`define PSQ_CLK_RST_SLEEP 5
`define PSQ_CLK_GATE_SBY_OFF 4
`define PSQ_CONV_SBY_OFF 0
`define PSQ_LIN3_PUMP_OFF 1
`define PSQ_LIN3_EXT_GATE_ON 0
`define PSQ_CTRL_ACK 7
`define PSQ_CTRL_STANDBY 6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PSQ_WAKE_TIMEOUT_US 1000
`define PSQ_CLK_MHZ 125

`endif

// ### core/psq_sync2.v
// two-flop synchroniser for a bus of asynchronous inputs
`timescale 1ns/10ps
`default_nettype none

module psq_sync2 #(
    parameter WIDTH = 1
) (
    input wire clk_sys_in, // system clock
    input wire arst_n_in, // async reset, active low
    input wire [WIDTH-1:0] async_in, // raw inputs
    output wire [WIDTH-1:0] sync_out // synchronised inputs
);
    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_r <= {WIDTH{1'b0}};
            sync_r <= {WIDTH{1'b0}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule // psq_sync2

`default_nettype wire

// ### tb/psq_host_model.sv
// host microcontroller model driving the three-wire load port
`timescale 1ns/10ps
`default_nettype none
module psq_host_model (
    input wire logic clk_sys_in, // time base
    output logic shift_clock_out = 1'b0, // still low between frames
    output logic serial_data_out = 1'b0, // frame bits
    output logic load_strobe_out = 1'b0 // load edge
);
    // low n bits of v go out msb first; half is one clock phase in system clocks
    task automatic send(input logic [23:0] v, input integer n, input integer half);
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge clk_sys_in);
            serial_data_out = v[i];
            repeat (half) @(negedge clk_sys_in);
            shift_clock_out = 1'b1;
            repeat (half) @(negedge clk_sys_in);
            shift_clock_out = 1'b0;
        end
        repeat (half) @(negedge clk_sys_in);
        // hold time over: leave no stale level on the data line
        serial_data_out = ~serial_data_out;
        load_strobe_out = 1'b1;
        repeat (half) @(negedge clk_sys_in);
        load_strobe_out = 1'b0;
    endtask
endmodule // psq_host_model
`default_nettype wire

// ### tb/psq_sequencer_monitor.sv
// port assertions of the power sequencer control block
`timescale 1ns/10ps
`default_nettype none
module psq_sequencer_monitor (
    input wire logic clk_sys_in, // clock
    input wire logic arst_n_in, // reset
    input wire logic ack_pin_in, // pin
    input wire logic rail_order_pick_in, // pin
    input wire logic rail1_internal_ok_in, // pin
    input wire logic rail2_internal_ok_in, // pin
    input wire logic wake_held_out, // out
    input wire logic gate_supply_on_out, // out
    input wire logic converter1_on_out, // out
    input wire logic converter2_on_out, // out
    input wire logic power_switch_1_on_out, // out
    input wire logic power_switch_2_on_out, // out
    input wire logic linear_regulator_1_on_out, // out
    input wire logic linear_regulator_2_on_out, // out
    input wire logic linear_regulator_3_on_out, // out
    input wire logic key_latch_pulldown_out, // out
    input wire logic rail1_ok_n_out, // out
    input wire logic rail2_ok_n_out // out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    wire logic lin_any = linear_regulator_1_on_out | linear_regulator_2_on_out
        | linear_regulator_3_on_out;
    wire logic any_run = lin_any | gate_supply_on_out | converter1_on_out | converter2_on_out
        | power_switch_1_on_out | power_switch_2_on_out;
    // input windows of five cycles cover the two-flop sync plus the output flop
    a_asleep_rails_off: assert property ((!wake_held_out)[*2] |-> !any_run)
        else $error("rail running while asleep");
    a_awake_gate_on: assert property (wake_held_out[*2] |-> gate_supply_on_out && converter1_on_out)
        else $error("booster or converter 1 idle while awake");
    a_lin_needs_rail1: assert property (
        (!(rail_order_pick_in ? rail2_internal_ok_in : rail1_internal_ok_in))[*5]
        |-> !lin_any) else $error("linear on without chosen rail good");
    a_conv2_needs_good: assert property ((!rail2_internal_ok_in)[*5] |->
        !converter2_on_out && !power_switch_1_on_out && !power_switch_2_on_out)
        else $error("late rails on without rail 2 good");
    a_switch2_needs_conv2: assert property (power_switch_2_on_out |-> converter2_on_out)
        else $error("switch 2 on with converter 2 off");
    a_rail1_rst_track: assert property ($stable(rail1_internal_ok_in)[*5] |->
        rail1_ok_n_out == rail1_internal_ok_in) else $error("rail 1 reset wrong");
    a_rail2_rst_track: assert property ($stable(rail2_internal_ok_in)[*5] |->
        rail2_ok_n_out == rail2_internal_ok_in) else $error("rail 2 reset wrong");
    a_pulldown_on_ack: assert property ((ack_pin_in && rail1_internal_ok_in)[*5] |->
        key_latch_pulldown_out) else $error("pulldown off during acknowledge");
    c_wake_seen: cover property ($rose(wake_held_out));
    c_all_on: cover property (converter2_on_out && power_switch_2_on_out);
    c_pulldown: cover property (key_latch_pulldown_out);
endmodule // psq_sequencer_monitor
bind psq_sequencer psq_sequencer_monitor u_mon (.*);
`default_nettype wire

// ### tb/tb_pmic_serial_control_sequencer.sv
// self-checking bench of the power sequencer control block
`timescale 1ns/10ps
`default_nettype none
module tb_pmic_serial_control_sequencer;
    localparam integer TMO = 400;
    logic clk_sys_in = 1'b0, arst_n_in = 1'b0, shift_clock_in, serial_data_in, load_strobe_in;
    logic ack_pin_in = 1'b0, standby_pin_in = 1'b0, rail_order_pick_in = 1'b0;
    logic rail1_internal_ok_in = 1'b0, rail2_internal_ok_in = 1'b0;
    logic rail1_external_ok_in = 1'b0, rail2_external_ok_in = 1'b0;
    logic gate_level_pick_1_in = 1'b0, gate_level_pick_2_in = 1'b0;
    logic [3:0] wake_n = 4'hf;
    wire wake_request_n_1_in = wake_n[0], wake_request_n_2_in = wake_n[1];
    wire wake_request_n_3_in = wake_n[2], wake_request_n_4_in = wake_n[3];
    logic wake_held_out, gate_supply_on_out, converter1_on_out, converter2_on_out;
    logic power_switch_1_on_out, power_switch_2_on_out, key_latch_pulldown_out;
    logic linear_regulator_1_on_out, linear_regulator_2_on_out, linear_regulator_3_on_out;
    logic rail1_ok_n_out, rail2_ok_n_out;
    logic [1:0] gate_level_out;
    logic [7:0] switching_clock_config_out, converter1_voltage_code_out, linear1_voltage_code_out;
    logic [7:0] converter2_voltage_code_out, linear2_voltage_code_out, linear3_voltage_code_out;
    wire [47:0] regs = {switching_clock_config_out, converter1_voltage_code_out,
        converter2_voltage_code_out, linear1_voltage_code_out, linear2_voltage_code_out,
        linear3_voltage_code_out};
    wire [7:0] rails = {gate_supply_on_out, converter1_on_out, converter2_on_out,
        power_switch_1_on_out, power_switch_2_on_out, linear_regulator_1_on_out,
        linear_regulator_2_on_out, linear_regulator_3_on_out};
    logic [47:0] shadow = 48'h0;
    logic [7:0] d;
    integer seed = 30, fail_count = 0, n_checks = 0, k, a;

    always #4 clk_sys_in = ~clk_sys_in;
    psq_sequencer #(.WAKE_TIMEOUT_CYC(TMO)) u_dut (.*);
    psq_host_model u_host (.clk_sys_in(clk_sys_in), .shift_clock_out(shift_clock_in),
        .serial_data_out(serial_data_in), .load_strobe_out(load_strobe_in));

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic settle;
        repeat (8) @(negedge clk_sys_in);
    endtask
    task automatic wait_wake(input logic v, input integer lim);
        for (int i = 0; i < lim && wake_held_out !== v; i++)
            @(negedge clk_sys_in);
        if (wake_held_out !== v) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    // expected run enables while awake, for rail mask m
    function automatic logic [7:0] exp_rails(input logic [7:0] m);
        logic good;
        logic lin;
        good = rail1_internal_ok_in & rail1_external_ok_in & rail2_internal_ok_in;
        lin = good | (rail_order_pick_in ? rail2_internal_ok_in : rail1_internal_ok_in);
        exp_rails = {1'b1, m[5], good & m[0], good & m[7], good & m[6] & m[0], {3{lin}} & m[3:1]};
    endfunction

    initial begin
        repeat (90000) @(posedge clk_sys_in);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        settle();
        chk(regs, 48'h0);
        chk(rails, 8'h00);
        $display("test reset done");
        // stray leading bits, refused addresses
        for (k = 0; k < 32; k++) begin
            a = (k % 16 == 1 || k % 16 == 8) ? 0 : k % 16;
            d = 8'($random(seed));
            u_host.send({12'($random(seed)), a[3:0], d}, 12 + k % 5, 5);
            settle();
            if (a >= 2 && a <= 7)
                shadow[(7 - a) * 8 +: 8] = d;
            chk(regs, shadow);
        end
        $display("test frames done");
        // mid-run reset: registers back to defaults, no fake wake edge
        arst_n_in = 1'b0;
        @(negedge clk_sys_in);
        arst_n_in = 1'b1;
        settle();
        shadow = 48'h0;
        chk(regs, shadow);
        chk(wake_held_out, 1'b0);
        for (k = 1; k <= 4; k++) begin
            d = 8'($random(seed));
            {gate_level_pick_2_in, gate_level_pick_1_in} = d[1:0];
            rail_order_pick_in = k[0];
            wake_n[k - 1] = 1'b0;
            wait_wake(1'b1, 20);
            chk(wake_held_out, 1'b1);
            settle();
            chk(rails, exp_rails(8'hff));
            chk(gate_level_out, d[1:0]);
            rail1_internal_ok_in = 1'b1;
            settle();
            chk(rails, exp_rails(8'hff));
            chk(rail1_ok_n_out, 1'b1);
            {rail1_external_ok_in, rail2_internal_ok_in, rail2_external_ok_in} = 3'h7;
            settle();
            chk(rails, exp_rails(8'hff));
            chk(rail2_ok_n_out, 1'b1);
            if (k == 4) begin
                u_host.send({12'h0, 4'h1, 8'hfe}, 12, 5);
                settle();
                chk(rails, exp_rails(8'hfe));
            end
            wake_n = 4'hf;
            if (k[0])
                ack_pin_in = 1'b1;
            else
                u_host.send({12'h0, 4'h8, 8'h80}, 12, 5);
            settle();
            chk(key_latch_pulldown_out, 1'b1);
            ack_pin_in = 1'b0;
            u_host.send({12'h0, 4'h8, 8'h00}, 12, 5);
            standby_pin_in = 1'b1;
            wait_wake(1'b0, 20);
            chk(wake_held_out, 1'b0);
            settle();
            chk({rails, key_latch_pulldown_out}, 9'h000);
            standby_pin_in = 1'b0;
            {rail1_internal_ok_in, rail1_external_ok_in} = 2'h0;
            {rail2_internal_ok_in, rail2_external_ok_in} = 2'h0;
            settle();
            chk({rail1_ok_n_out, rail2_ok_n_out}, 2'h0);
            $display("test wake %0d done", k);
        end
        wake_n[1] = 1'b0;
        wait_wake(1'b1, 20);
        repeat (TMO - 40) @(negedge clk_sys_in);
        chk(wake_held_out, 1'b1);
        wait_wake(1'b0, 60);
        chk(wake_held_out, 1'b0);
        // latch still set after the timeout: a fresh request must be ignored
        wake_n = 4'hf;
        settle();
        wake_n[2] = 1'b0;
        settle();
        chk(wake_held_out, 1'b0);
        $display("test timeout done");
        report_and_stop();
    end
endmodule // tb_pmic_serial_control_sequencer
`default_nettype wire
